// file: hw/cxr_defs.vh
`ifndef CXR_DEFS_VH
`define CXR_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CXR_OFS_FRAME_HDR 8'h00
`define CXR_OFS_FRAME_VAL 8'h04
`define CXR_OFS_FRAME_CSUM 8'h08
`define CXR_OFS_CTRL 8'h0c
`define CXR_OFS_STATUS 8'h10
`define CXR_OFS_REPLY_VAL 8'h14
`define CXR_OFS_ACCU 8'h18
`define CXR_OFS_XREG 8'h1c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CXR_CTRL_STANDALONE 0
`define CXR_CTRL_PERSIST 1
`define CXR_CTRL_RESET 2'b00
`define CXR_STAT_BUSY 0
`define CXR_STAT_VALID 1
`define CXR_STAT_CODE_LSB 8
`define CXR_MODULE_ADDR 8'h01

// ----------------------------------------------------------------------
// Opcodes, operation types, motor and coordinate limits
// ----------------------------------------------------------------------
`define CXR_OP_COORD_READ 8'h1f
`define CXR_OP_CAPTURE 8'h20
`define CXR_OP_XREG_ARITH 8'h21
`define CXR_OP_ACCU_TO_COORD 8'h27
`define CXR_CALC_ADD 8'h00
`define CXR_CALC_SUB 8'h01
`define CXR_CALC_MUL 8'h02
`define CXR_CALC_DIV 8'h03
`define CXR_CALC_MOD 8'h04
`define CXR_CALC_AND 8'h05
`define CXR_CALC_OR 8'h06
`define CXR_CALC_XOR 8'h07
`define CXR_CALC_NOT 8'h08
`define CXR_CALC_LOAD 8'h09
`define CXR_CALC_SWAP 8'h0a
`define CXR_MOTOR_ALL 8'hff
`define CXR_MOTOR_MAX 8'h05
`define CXR_MOTOR_LAST 3'd5
`define CXR_COORD_MAX 8'h14
`define CXR_COORD_LAST 5'd20
`define CXR_COORD_FIRST 5'd1

// ----------------------------------------------------------------------
// Reply status codes
// ----------------------------------------------------------------------
`define CXR_ST_OK 8'h64
`define CXR_ST_BAD_CSUM 8'h01
`define CXR_ST_BAD_CMD 8'h02
`define CXR_ST_BAD_TYPE 8'h03
`define CXR_ST_BAD_VALUE 8'h04

`endif

// file: hw/cxr_coord_mem.v
`timescale 1ns/1ps
`default_nettype none

module cxr_coord_mem (
  // Clock
  input wire pclk,
  // Write port
  input wire we,
  input wire [7:0] waddr,
  input wire [31:0] wdata,
  // Read port, data registered
  input wire [7:0] raddr,
  output reg [31:0] rdata
);

  reg [31:0] mem [0:255];

  // No reset on the array: contents after power-up are undefined
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // cxr_coord_mem

`default_nettype wire

// file: hw/cxr_coord_xreg.v
// Overview of operation
// R1 - In standalone mode a coordinate read copies the addressed entry into the accumulator.
// R2 - In direct mode a coordinate read returns the entry in the reply with status 100 and keeps the accumulator.
// R3 - Coordinate 0 with motor 255 restores entries 1 to 20 of every motor from storage into RAM.
// R4 - A nonzero coordinate with motor 255 restores only that entry, and a coordinate above 20 is refused with status 4.
// R5 - Entry zero lives in RAM only and is never stored to or restored from storage.
// R6 - The persistence setting chooses RAM only or RAM plus storage and resets to RAM only.
// R7 - The capture command copies the motor's actual position into the addressed entry.
// R8 - The accumulator-to-coordinate command writes the accumulator into the entry and replies 100.
// R9 - The X-register arithmetic command takes its second operand from X and writes the accumulator for types 0 to 7 and 10.
// R10 - Types 0 to 4 add, subtract, multiply, divide and take the modulo by X.
// R11 - Types 5 to 7 AND, OR and XOR the accumulator with X into the accumulator.
// R12 - Type 8 inverts the X register.
// R13 - Type 9 copies the accumulator into X and keeps the accumulator.
// R14 - Type 10 swaps accumulator and X in one step.
// R15 - The capture reply carries status 100 and the captured value.
// R16 - Twenty coordinates per motor are stored, addressed by coordinate and motor.
// R17 - A frame is nine bytes with a checksum equal to the low byte of the sum of the first eight.
`timescale 1ns/1ps
`default_nettype none
`include "cxr_defs.vh"

module cxr_coord_xreg (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Actual positions, motor n in bits 32n+31..32n
  input wire [191:0] actual_pos
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_EXEC = 3'd1;
  localparam ST_READ = 3'd2;
  localparam ST_RST_RD = 3'd3;
  localparam ST_RST_WR = 3'd4;

  reg [2:0] state;
  reg [31:0] frame_hdr;
  reg [31:0] frame_val;
  reg [1:0] ctrl;
  reg [7:0] reply_code;
  reg [31:0] reply_val;
  reg reply_valid;
  reg [31:0] accu;
  reg [31:0] xreg;
  reg [2:0] rmot;
  reg [4:0] rcoord;
  reg rall;

  wire [7:0] op = frame_hdr[23:16];
  wire [7:0] typ = frame_hdr[15:8];
  wire [7:0] mot = frame_hdr[7:0];
  wire busy = (state != ST_IDLE);
  wire standalone = ctrl[`CXR_CTRL_STANDALONE];
  wire persist = ctrl[`CXR_CTRL_PERSIST];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  // Word-aligned offsets up to the X register are mapped
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `CXR_OFS_XREG);
  wire wr = access & pwrite & mapped;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Checksum: running modulo-256 sum over the eight leading bytes
  wire [63:0] frame_bytes = {frame_hdr, frame_val};
  wire [7:0] run_sum [0:8];

  assign run_sum[0] = 8'h00;
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb = gb + 1) begin : g_csum
      assign run_sum[gb+1] = run_sum[gb] + frame_bytes[8*gb+7:8*gb];
    end
  endgenerate
  wire [7:0] fsum = run_sum[8];
  wire launch = wr & (paddr == `CXR_OFS_FRAME_CSUM) & ~busy;
  wire csum_ok = (pwdata[7:0] == fsum); // [R17]
  wire for_us = (frame_hdr[31:24] == `CXR_MODULE_ADDR);

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Status word: reply code in the second byte, flags in the low bits
  wire [31:0] status_word = {16'h0000, reply_code, 6'h00, reply_valid, busy};

  // Read data captured in the setup phase so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      case (paddr)
        `CXR_OFS_FRAME_HDR: prdata <= frame_hdr;
        `CXR_OFS_FRAME_VAL: prdata <= frame_val;
        `CXR_OFS_CTRL: prdata <= {30'h00000000, ctrl};
        `CXR_OFS_STATUS: prdata <= status_word;
        `CXR_OFS_REPLY_VAL: prdata <= reply_val;
        `CXR_OFS_ACCU: prdata <= accu;
        `CXR_OFS_XREG: prdata <= xreg;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Per-motor position words
  // ----------------------------------------------------------------------
  // Positions come from the same clock domain, so no synchroniser
  wire [31:0] pos_word [0:5];
  reg [31:0] cur_pos;

  genvar gm;
  generate
    for (gm = 0; gm < 6; gm = gm + 1) begin : g_pos
      assign pos_word[gm] = actual_pos[32*gm+31:32*gm];
    end
  endgenerate

  // Motor codes 6 and 7 give zero rather than an out-of-range slice
  always @* begin
    case (mot[2:0])
      3'd0: cur_pos = pos_word[0];
      3'd1: cur_pos = pos_word[1];
      3'd2: cur_pos = pos_word[2];
      3'd3: cur_pos = pos_word[3];
      3'd4: cur_pos = pos_word[4];
      3'd5: cur_pos = pos_word[5];
      default: cur_pos = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Coordinate arrays: working RAM and persistent store
  // ----------------------------------------------------------------------
  wire [7:0] cmd_addr = {mot[2:0], typ[4:0]};
  wire [7:0] rst_addr = {rmot, rcoord};
  wire motor_ok = (mot <= `CXR_MOTOR_MAX);
  wire coord_ok = (typ <= `CXR_COORD_MAX); // [R16]
  wire store_cmd = (state == ST_EXEC) && motor_ok && coord_ok &&
    ((op == `CXR_OP_CAPTURE) || (op == `CXR_OP_ACCU_TO_COORD));
  wire [31:0] store_val = (op == `CXR_OP_CAPTURE) ? cur_pos : accu; // [R7] [R8]
  wire [31:0] ram_rdata;
  wire [31:0] nv_rdata;

  wire ram_we = store_cmd | (state == ST_RST_WR);
  wire [7:0] ram_waddr = (state == ST_RST_WR) ? rst_addr : cmd_addr;
  wire [31:0] ram_wdata = (state == ST_RST_WR) ? nv_rdata : store_val;
  // Entry zero never reaches the store
  wire nv_we = store_cmd & persist & (typ != 8'h00); // [R5] [R6]

  cxr_coord_mem u_ram (
    .pclk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(cmd_addr),
    .rdata(ram_rdata)
  );

  cxr_coord_mem u_nv (
    .pclk(pclk),
    .we(nv_we),
    .waddr(cmd_addr),
    .wdata(store_val),
    .raddr(rst_addr),
    .rdata(nv_rdata)
  );

  // ----------------------------------------------------------------------
  // Accumulator and X register arithmetic
  // ----------------------------------------------------------------------
  wire signed [31:0] sa = accu;
  wire signed [31:0] sx = xreg;
  wire signed [63:0] prod = sa * sx;
  wire x_zero = (xreg == 32'h00000000);
  // Division by zero would be undefined; the accumulator is kept instead
  wire signed [31:0] quo = x_zero ? sa : sa / sx;
  wire signed [31:0] rem = x_zero ? sa : sa % sx;
  reg [31:0] next_accu;
  reg [31:0] next_xreg;
  reg calc_ok;

  always @* begin
    next_accu = accu;
    next_xreg = xreg;
    calc_ok = 1'b1;
    case (typ)
      `CXR_CALC_ADD: next_accu = accu + xreg; // [R9] [R10]
      `CXR_CALC_SUB: next_accu = accu - xreg; // [R10]
      `CXR_CALC_MUL: next_accu = prod[31:0]; // [R10]
      `CXR_CALC_DIV: next_accu = quo; // [R10]
      `CXR_CALC_MOD: next_accu = rem; // [R10]
      `CXR_CALC_AND: next_accu = accu & xreg; // [R11]
      `CXR_CALC_OR: next_accu = accu | xreg; // [R11]
      `CXR_CALC_XOR: next_accu = accu ^ xreg; // [R11]
      `CXR_CALC_NOT: next_xreg = ~xreg; // [R12]
      `CXR_CALC_LOAD: next_xreg = accu; // [R13]
      `CXR_CALC_SWAP: begin
        next_accu = xreg; // [R14]
        next_xreg = accu; // [R14]
      end
      default: calc_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      frame_hdr <= 32'h00000000;
      frame_val <= 32'h00000000;
      ctrl <= `CXR_CTRL_RESET; // [R6]
      reply_code <= 8'h00;
      reply_val <= 32'h00000000;
      reply_valid <= 1'b0;
      accu <= 32'h00000000;
      xreg <= 32'h00000000;
      rmot <= 3'd0;
      rcoord <= `CXR_COORD_FIRST;
      rall <= 1'b0;
    end else begin
      // Software writes are held off while a command runs
      if (wr && !busy) begin
        case (paddr)
          `CXR_OFS_FRAME_HDR: frame_hdr <= pwdata;
          `CXR_OFS_FRAME_VAL: frame_val <= pwdata;
          `CXR_OFS_CTRL: ctrl <= pwdata[1:0];
          `CXR_OFS_ACCU: accu <= pwdata;
          `CXR_OFS_XREG: xreg <= pwdata;
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (launch && for_us) begin
            reply_valid <= 1'b0;
            if (csum_ok) begin
              state <= ST_EXEC;
            end else begin
              reply_code <= `CXR_ST_BAD_CSUM; // [R17]
              reply_val <= 32'h00000000;
              reply_valid <= 1'b1;
            end
          end
        end
        ST_EXEC: begin
          reply_code <= `CXR_ST_OK;
          reply_val <= 32'h00000000;
          state <= ST_IDLE;
          reply_valid <= 1'b1;
          case (op)
            `CXR_OP_COORD_READ: begin
              if (mot == `CXR_MOTOR_ALL && coord_ok) begin
                rall <= (typ == 8'h00); // [R3] [R4]
                rmot <= 3'd0;
                // Entry zero is skipped even for a full restore
                rcoord <= (typ == 8'h00) ? `CXR_COORD_FIRST :
                  typ[4:0]; // [R5]
                reply_valid <= 1'b0;
                state <= ST_RST_RD;
              end else if (motor_ok && coord_ok) begin
                reply_valid <= 1'b0;
                state <= ST_READ;
              end else begin
                reply_code <= `CXR_ST_BAD_VALUE;
              end
            end
            `CXR_OP_CAPTURE: begin
              if (motor_ok && coord_ok) begin
                reply_val <= cur_pos; // [R15]
              end else begin
                reply_code <= `CXR_ST_BAD_VALUE;
              end
            end
            `CXR_OP_ACCU_TO_COORD: begin
              if (!(motor_ok && coord_ok)) begin
                reply_code <= `CXR_ST_BAD_VALUE; // [R8]
              end
            end
            `CXR_OP_XREG_ARITH: begin
              if (calc_ok) begin
                accu <= next_accu; // [R9]
                xreg <= next_xreg;
              end else begin
                reply_code <= `CXR_ST_BAD_TYPE;
              end
            end
            default: reply_code <= `CXR_ST_BAD_CMD;
          endcase
        end
        ST_READ: begin
          if (standalone) begin
            accu <= ram_rdata; // [R1]
          end else begin
            reply_val <= ram_rdata; // [R2]
          end
          reply_valid <= 1'b1;
          state <= ST_IDLE;
        end
        ST_RST_RD: begin
          // A full restore walks six motors of twenty entries, two cycles each
          state <= ST_RST_WR;
        end
        ST_RST_WR: begin
          // Entry written to RAM this cycle; step to the next one
          state <= ST_RST_RD;
          if (rall && rcoord != `CXR_COORD_LAST) begin
            rcoord <= rcoord + 5'd1; // [R3]
          end else begin
            rcoord <= rall ? `CXR_COORD_FIRST : rcoord; // [R4]
            if (rmot == `CXR_MOTOR_LAST) begin
              reply_valid <= 1'b1;
              state <= ST_IDLE;
            end else begin
              rmot <= rmot + 3'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // cxr_coord_xreg

`default_nettype wire

// file: testbench/cxr_coord_xreg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cxr_coord_xreg_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Positions
  input wire logic [191:0] actual_pos
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic high = paddr > 8'h1c;
  wire logic odd = paddr[1:0] != 2'b00;

  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && high |-> pslverr)
    else $error("no error on unmapped address");
  a_err_unaligned: assert property (acc && odd |-> pslverr)
    else $error("no error on unaligned address");
  a_err_mapped: assert property (acc && !high && !odd |-> !pslverr)
    else $error("error on mapped address");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  a_err_rdata: assert property (acc && !pwrite && (high || odd) |->
    prdata == 32'h0) else $error("read data on refused read");
  a_csum_zero: assert property (
    acc && !pwrite && paddr == 8'h08 |-> prdata == 32'h0)
    else $error("checksum register reads nonzero");
  a_rdata_held: assert property (
    $changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved outside read setup");

  c_refused: cover property (acc && pslverr);
  c_launch: cover property (acc && pwrite && paddr == 8'h08);
  c_done: cover property (acc && !pwrite && paddr == 8'h10 &&
    prdata[1:0] == 2'b10);
endmodule // cxr_coord_xreg_props

bind cxr_coord_xreg cxr_coord_xreg_props i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .actual_pos(actual_pos));
`default_nettype wire

// file: testbench/cxr_pos_model.sv
`timescale 1ns/1ps
`default_nettype none
module cxr_pos_model (
  // Base value set by the bench
  input wire logic [31:0] base,
  // Actual positions, one word per motor
  output logic [191:0] actual_pos
);
  // Distinct words per motor, so a wrong motor index shows up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      actual_pos[32*i +: 32] = base + 32'h0101_0000 * i;
    end
  end
endmodule // cxr_pos_model
`default_nettype wire

// file: testbench/tb_cxr_coord_xreg.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cxr_coord_xreg;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] base = 32'h1234_0000;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic [191:0] actual_pos;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] r;
  logic [7:0] code;
  logic e;
  logic [31:0] ea [11] = '{32'hfd, 32'hef, 32'h6ba, 32'h23, 32'h01,
    32'h06, 32'hf7, 32'hf1, 32'hf6, 32'hf6, 32'h07};
  logic [31:0] ex [11] = '{32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h7,
    32'h7, 32'h7, 32'hffff_fff8, 32'hf6, 32'hf6};

  always #2.5 pclk = ~pclk;

  cxr_coord_xreg i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .actual_pos(actual_pos));
  cxr_pos_model i_pos (.base(base), .actual_pos(actual_pos));

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask

  // Idle edge first, so a release never meets the next setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x,
                    input string s);
    apb(1'b0, a, 32'h0);
    chk(s, x, r);
  endtask

  task automatic cc(input logic [7:0] x);
    chk("code", {24'h0, x}, {24'h0, code});
  endtask

  task automatic send(input logic [7:0] op, ty, mo,
                      input logic [31:0] v, input logic [7:0] cx = 8'h00);
    logic [31:0] h;
    logic [7:0] cs;
    int n;
    h = {8'h01, op, ty, mo};
    cs = h[31:24] + h[23:16] + h[15:8] + h[7:0] + v[31:24] + v[23:16]
      + v[15:8] + v[7:0];
    apb(1'b1, 8'h00, h);
    apb(1'b1, 8'h04, v);
    apb(1'b1, 8'h08, {24'h0, cs ^ cx});
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      n++;
    end while (r[1:0] !== 2'b10 && n < 300);
    if (n >= 300) begin
      fail_count++;
      conclude();
    end
    code = r[15:8];
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h0c, 32'h0, "ctrl");
    rc(8'h10, 32'h0, "status");
    rc(8'h08, 32'h0, "csum_read");
    send(8'h20, 8'h03, 8'h02, 32'h0);
    cc(8'h64);
    rc(8'h14, base + 32'h0202_0000, "capture");
    apb(1'b1, 8'h18, 32'h5a5a_0001);
    send(8'h1f, 8'h03, 8'h02, 32'h0);
    rc(8'h14, base + 32'h0202_0000, "reply");
    rc(8'h18, 32'h5a5a_0001, "accu_kept");
    apb(1'b1, 8'h0c, 32'h1);
    send(8'h1f, 8'h03, 8'h02, 32'h0);
    rc(8'h18, base + 32'h0202_0000, "accu_read");
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h18, 32'hcafe_0014);
    send(8'h27, 8'h14, 8'h05, 32'h0);
    cc(8'h64);
    send(8'h1f, 8'h14, 8'h05, 32'h0);
    rc(8'h14, 32'hcafe_0014, "last_entry");
    send(8'h1f, 8'h15, 8'h05, 32'h0);
    cc(8'h04);
    send(8'h1f, 8'h03, 8'h06, 32'h0);
    cc(8'h04);
    send(8'h30, 8'h00, 8'h00, 32'h0);
    cc(8'h02);
    send(8'h1f, 8'h03, 8'h00, 32'h0, 8'h01);
    cc(8'h01);
    // Store holds A for entry 1; RAM then takes B in entries 0 and 1 of motor 0
    apb(1'b1, 8'h0c, 32'h2);
    apb(1'b1, 8'h18, 32'h0000_a0a0);
    send(8'h27, 8'h01, 8'h00, 32'h0);
    send(8'h27, 8'h00, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h18, 32'h0000_b0b0);
    send(8'h27, 8'h01, 8'h00, 32'h0);
    send(8'h27, 8'h00, 8'h00, 32'h0);
    send(8'h1f, 8'h00, 8'hff, 32'h0);
    cc(8'h64);
    send(8'h1f, 8'h01, 8'h00, 32'h0);
    rc(8'h14, 32'h0000_a0a0, "restore_all");
    send(8'h1f, 8'h00, 8'h00, 32'h0);
    rc(8'h14, 32'h0000_b0b0, "entry0");
    apb(1'b1, 8'h0c, 32'h2);
    apb(1'b1, 8'h18, 32'h0000_c0c0);
    send(8'h27, 8'h02, 8'h01, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h18, 32'h0000_d0d0);
    send(8'h27, 8'h02, 8'h01, 32'h0);
    send(8'h27, 8'h01, 8'h00, 32'h0);
    send(8'h1f, 8'h02, 8'hff, 32'h0);
    cc(8'h64);
    send(8'h1f, 8'h02, 8'h01, 32'h0);
    rc(8'h14, 32'h0000_c0c0, "restore_one");
    send(8'h1f, 8'h01, 8'h00, 32'h0);
    rc(8'h14, 32'h0000_d0d0, "not_restored");
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, 8'h18, 32'hf6);
      apb(1'b1, 8'h1c, 32'h7);
      send(8'h21, i[7:0], 8'h00, 32'h0);
      cc(8'h64);
      rc(8'h18, ea[i], "accu");
      rc(8'h1c, ex[i], "xreg");
    end
    send(8'h21, 8'h0b, 8'h00, 32'h0);
    cc(8'h03);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    conclude();
  end
endmodule // tb_cxr_coord_xreg
`default_nettype wire
